// [hdl/pwp_map.svh]
// Register offsets, bit positions and reset values of the write protect block
`ifndef PWP_MAP_SVH
`define PWP_MAP_SVH

// Byte offsets inside each instance window
`define PWP_CLEAR_OFFSET 3'h0
`define PWP_SET_OFFSET 3'h4
// Instance windows, base byte address of each
`define PWP_CORE_BASE 8'h00
`define PWP_SYS_BASE 8'h10

// Core instance flag positions
`define PWP_BIT_EXTINT 6
`define PWP_BIT_RTC 5
`define PWP_BIT_WATCHDOG 4
`define PWP_BIT_CLOCKGEN 3
`define PWP_BIT_SYSCTL 2
`define PWP_BIT_POWERMGR 1
// System instance flag positions
`define PWP_BIT_TRACE 6
`define PWP_BIT_PINCTL 3
`define PWP_BIT_FLASHCTL 2
`define PWP_BIT_DEBUG 1

// Implemented bits of each instance
`define PWP_CORE_MASK 32'h0000007e
`define PWP_SYS_MASK 32'h0000004e
// Reset values
`define PWP_CORE_RESET 32'h00000000
`define PWP_SYS_RESET 32'h00000002

`endif

// [hdl/pwp_pkg.sv]
// Types shared by the write protect block
package pwp_pkg;
    // APB access phase states
    typedef enum logic [0:0] {
        PWP_IDLE = 1'b0,
        PWP_ACCESS = 1'b1
    } pwp_apb_state_t;
    typedef logic [31:0] pwp_word_t;
endpackage

// [hdl/pwp_flag_bank.sv]
// One bank of write protect flags with clear and set write ports
`timescale 1ns/100ps
module pwp_flag_bank #(
    parameter logic [31:0] MASK = 32'h0,
    parameter logic [31:0] RESETVAL = 32'h0
) (
    input wire logic mclk, // Clock
    input wire logic reset, // Async reset, active high
    input wire logic clearWe, // Write strobe, clear register
    input wire logic setWe, // Write strobe, set register
    input wire logic [31:0] wdata, // Write data
    output logic [31:0] flags // Current protection flags
);
    logic [31:0] flags_reg;
    logic [31:0] flags_next;

    // Per-bit update; zeros leave the flag alone
    always_comb begin
        flags_next = flags_reg;
        if (clearWe) begin
            flags_next = flags_reg & ~(wdata & MASK);
        end
        if (setWe) begin
            flags_next = flags_reg | (wdata & MASK);
        end
    end

    // Unused bits stay zero since the mask keeps them out
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            flags_reg <= RESETVAL;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign flags = flags_reg;
endmodule

// [hdl/pwp_apb_slave.sv]
// APB slave decode for the write protect block
`timescale 1ns/100ps
module pwp_apb_slave (
    input wire logic mclk, // Clock
    input wire logic reset, // Async reset, active high
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    output logic accessEn, // Access phase, one cycle
    output logic pready // Ready, registered
);
    pwp_pkg::pwp_apb_state_t state_reg;
    pwp_pkg::pwp_apb_state_t state_next;

    // No wait states: ready rises in the first access cycle
    always_comb begin
        case (state_reg)
            pwp_pkg::PWP_IDLE: begin
                state_next = (psel && !penable) ? pwp_pkg::PWP_ACCESS
                                                : pwp_pkg::PWP_IDLE;
            end
            pwp_pkg::PWP_ACCESS: begin
                state_next = pwp_pkg::PWP_IDLE;
            end
            default: begin
                state_next = pwp_pkg::PWP_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_reg <= pwp_pkg::PWP_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign pready = (state_reg == pwp_pkg::PWP_ACCESS);
    assign accessEn = pready && psel && penable;
endmodule

// [hdl/pwp_top.sv]
// Peripheral write protect controller, two instances behind one APB slave
//
// Summary of operation
// - Writing a zero to any flag position in clear or set leaves it as is.
// - Writing a one to clear removes protection; reads show 1 if protected.
// - Core bank bits 6..1 are ext interrupt, RTC, watchdog, clock gen, sysctl, power.
// - System bank bits 6,3,2,1 are trace, pin ctl, flash ctl, debug; others unused.
// - System bank resets to 0x000002, core bank resets to 0x000000.
`timescale 1ns/100ps
`include "pwp_map.svh"
module pwp_top (
    input wire logic mclk, // Clock, 100 MHz
    input wire logic reset, // Async reset, active high
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction, high for write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    output logic extIntProtect, // External interrupt unit locked
    output logic rtcProtect, // Real-time counter locked
    output logic watchdogProtect, // Watchdog unit locked
    output logic clockGenProtect, // Clock generator unit locked
    output logic sysCtlProtect, // System control unit locked
    output logic powerMgrProtect, // Power manager unit locked
    output logic traceProtect, // Trace buffer unit locked
    output logic pinCtlProtect, // Pin controller locked
    output logic flashCtlProtect, // Flash controller unit locked
    output logic debugProtect // Debug service unit locked
);
    logic accessEn;
    logic readyInt;
    logic [31:0] coreFlags;
    logic [31:0] sysFlags;
    logic coreHit;
    logic sysHit;
    logic isSet;
    logic mapped;
    logic coreClrWe;
    logic coreSetWe;
    logic sysClrWe;
    logic sysSetWe;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic slverr_reg;
    logic slverr_next;

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake
    pwp_apb_slave u_apb (
        .mclk(mclk),
        .reset(reset),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .accessEn(accessEn),
        .pready(readyInt)
    );

    ////////////////////////////////////////////////////////////////////////
    // Address decode; any offset in a window that is not 0 or 4 errs
    assign coreHit = (paddr[7:3] == 5'(`PWP_CORE_BASE >> 3));
    assign sysHit = (paddr[7:3] == 5'(`PWP_SYS_BASE >> 3));
    assign isSet = (paddr[2:0] == `PWP_SET_OFFSET);
    assign mapped = (coreHit || sysHit)
        && ((paddr[2:0] == `PWP_CLEAR_OFFSET) || isSet);

    // Strobes fire only at the completing edge
    assign coreClrWe = accessEn && pwrite && mapped && coreHit && !isSet;
    assign coreSetWe = accessEn && pwrite && mapped && coreHit && isSet;
    assign sysClrWe = accessEn && pwrite && mapped && sysHit && !isSet;
    assign sysSetWe = accessEn && pwrite && mapped && sysHit && isSet;

    ////////////////////////////////////////////////////////////////////////
    // Flag banks
    pwp_flag_bank #(
        .MASK(`PWP_CORE_MASK),
        .RESETVAL(`PWP_CORE_RESET)
    ) u_core (
        .mclk(mclk),
        .reset(reset),
        .clearWe(coreClrWe),
        .setWe(coreSetWe),
        .wdata(pwdata),
        .flags(coreFlags)
    );

    pwp_flag_bank #(
        .MASK(`PWP_SYS_MASK),
        .RESETVAL(`PWP_SYS_RESET)
    ) u_sys (
        .mclk(mclk),
        .reset(reset),
        .clearWe(sysClrWe),
        .setWe(sysSetWe),
        .wdata(pwdata),
        .flags(sysFlags)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read data held after the access; set and clear read the same flags
    always_comb begin
        rdata_next = rdata_reg;
        slverr_next = 1'b0;
        if (psel && !penable) begin
            rdata_next = 32'h00000000;
            if (!pwrite && coreHit && mapped) begin
                rdata_next = coreFlags;
            end else if (!pwrite && sysHit && mapped) begin
                rdata_next = sysFlags;
            end
            slverr_next = !mapped;
        end else if (psel && penable) begin
            // Access lasts one cycle, so the error flop drops after it
            slverr_next = 1'b0;
            // Refresh in case a write landed between setup and access
            if (!pwrite && coreHit && mapped) begin
                rdata_next = coreFlags;
            end else if (!pwrite && sysHit && mapped) begin
                rdata_next = sysFlags;
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rdata_reg <= 32'h00000000;
            slverr_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            slverr_reg <= slverr_next;
        end
    end

    assign prdata = rdata_reg;
    assign pready = readyInt;
    // Error flop is only ever high in the access cycle, so no gating
    assign pslverr = slverr_reg;

    ////////////////////////////////////////////////////////////////////////
    // Per-peripheral lock outputs, straight from the flag flip-flops
    assign extIntProtect = coreFlags[`PWP_BIT_EXTINT];
    assign rtcProtect = coreFlags[`PWP_BIT_RTC];
    assign watchdogProtect = coreFlags[`PWP_BIT_WATCHDOG];
    assign clockGenProtect = coreFlags[`PWP_BIT_CLOCKGEN];
    assign sysCtlProtect = coreFlags[`PWP_BIT_SYSCTL];
    assign powerMgrProtect = coreFlags[`PWP_BIT_POWERMGR];
    assign traceProtect = sysFlags[`PWP_BIT_TRACE];
    assign pinCtlProtect = sysFlags[`PWP_BIT_PINCTL];
    assign flashCtlProtect = sysFlags[`PWP_BIT_FLASHCTL];
    assign debugProtect = sysFlags[`PWP_BIT_DEBUG];

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic [31:0] pwdata_q;
    logic [31:0] coreFlags_q;
    logic [31:0] sysFlags_q;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pwdata_q <= 32'h00000000;
            coreFlags_q <= 32'h00000000;
            sysFlags_q <= 32'h00000000;
        end else begin
            pwdata_q <= pwdata;
            coreFlags_q <= coreFlags;
            sysFlags_q <= sysFlags;
        end
    end

    chk_clear_write: assert property (
        @(posedge mclk) disable iff (reset)
        coreClrWe |=> ((coreFlags & (pwdata_q & `PWP_CORE_MASK)) == 32'h0))
        else $error("clear write left a flag set");

    chk_zero_keeps: assert property (
        @(posedge mclk) disable iff (reset)
        (sysClrWe || sysSetWe) |=>
        (((sysFlags ^ sysFlags_q) & ~pwdata_q) == 32'h0))
        else $error("zero bit changed a flag");

    chk_set_write: assert property (
        @(posedge mclk) disable iff (reset)
        sysSetWe |=> ((sysFlags & pwdata_q & `PWP_SYS_MASK)
        == (pwdata_q & `PWP_SYS_MASK)))
        else $error("set write did not protect");

    chk_unused_bits: assert property (
        @(posedge mclk) disable iff (reset)
        ((sysFlags & ~`PWP_SYS_MASK) == 32'h0)
        && ((coreFlags & ~`PWP_CORE_MASK) == 32'h0))
        else $error("unused flag bit set");

    // Ext interrupt and power manager lock pins follow a core set write on the bits that were written
    chk_core_map: assert property (
        @(posedge mclk) disable iff (reset)
        coreSetWe |=>
        ((extIntProtect == (coreFlags_q[6] | pwdata_q[6]))
        && (powerMgrProtect == (coreFlags_q[1] | pwdata_q[1]))))
        else $error("core lock mapping wrong");

    chk_reset_value: assert property (
        @(posedge mclk)
        $fell(reset) |-> (sysFlags == 32'h2 && coreFlags == 32'h0))
        else $error("wrong reset flags");

    chk_read_data: assert property (
        @(posedge mclk) disable iff (reset)
        (psel && !penable && !pwrite && sysHit && mapped)
        |=> (prdata == sysFlags_q))
        else $error("read did not return flags");

    chk_no_spurious: assert property (
        @(posedge mclk) disable iff (reset)
        !(coreClrWe || coreSetWe) |=> $stable(coreFlags))
        else $error("core flags moved without write");
endmodule

// [verification/pwp_testbench.sv]
// Self-checking testbench for the write protect controller
`timescale 1ns/100ps
module testbench;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [9:0] locks;
    logic [31:0] coreExp = 32'h0;
    logic [31:0] sysExp = 32'h2;
    logic [33:0] expQ[$];
    logic [33:0] expNow;
    logic [7:0] addrTab[8] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h08, 8'h18,
        8'hfc, 8'h0c};
    int bad_count = 0;
    int checked = 0;

    // Free running 100 MHz clock
    always #5 mclk = ~mclk;

    pwp_top DUT (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .extIntProtect(locks[9]),
        .rtcProtect(locks[8]), .watchdogProtect(locks[7]),
        .clockGenProtect(locks[6]), .sysCtlProtect(locks[5]),
        .powerMgrProtect(locks[4]), .traceProtect(locks[3]),
        .pinCtlProtect(locks[2]), .flashCtlProtect(locks[1]),
        .debugProtect(locks[0]));

    ////////////////////////////////////////////////////////////////////////
    // Verdict, the only place the run ends
    task report_and_stop;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Compare tasks, one per kind of result
    task cmp_word(input string what, input logic [31:0] e,
        input logic [31:0] s);
        checked++;
        if (s !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask
    task cmp_bit(input string what, input logic e, input logic s);
        checked++;
        if (s !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %b seen %b", what, e, s);
        end
    endtask
    task check_locks;
        @(negedge mclk);
        checked++;
        if (locks !== {coreExp[6:1], sysExp[6], sysExp[3:1]}) begin
            bad_count++;
            $display("CHECK FAILED locks expected %b seen %b",
                {coreExp[6:1], sysExp[6], sysExp[3:1]}, locks);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Reset for two cycles; model returns to its power-up state
    task do_reset;
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        coreExp = 32'h0;
        sysExp = 32'h2;
    endtask

    // APB transfer; an idle cycle first so psel is never set twice at once
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        logic mapped;
        mapped = (a == 8'h00 || a == 8'h04 || a == 8'h10 || a == 8'h14);
        expQ.push_back({~wr, ~mapped, mapped ? (a[4] ? sysExp : coreExp)
            : 32'h0});
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // Request stands until pready is seen high at a rising edge
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            bad_count++;
            $display("CHECK FAILED pready expected 1 seen %b", pready);
            report_and_stop();
        end else begin
            psel <= 1'b0;
            penable <= 1'b0;
            // Only live bits (core 6..1, system 6,3,2,1) move, and only on ones
            if (wr && mapped) begin
                case (a)
                    8'h00: coreExp = coreExp & ~(d & 32'h7e);
                    8'h04: coreExp = coreExp | (d & 32'h7e);
                    8'h10: sysExp = sysExp & ~(d & 32'h4e);
                    default: sysExp = sysExp | (d & 32'h4e);
                endcase
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watches every completed transfer and compares with the oldest note
    always @(negedge mclk) begin
        if (psel && penable && pready === 1'b1) begin
            if (expQ.size() == 0) begin
                bad_count++;
                $display("CHECK FAILED queue expected note seen none");
            end else begin
                expNow = expQ.pop_front();
                cmp_bit("pslverr", expNow[32], pslverr);
                if (expNow[33])
                    cmp_word("prdata", expNow[31:0], prdata);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(50));
        do_reset();
        for (int i = 0; i < 4; i++)
            apb(1'b0, addrTab[i], 32'h0);
        check_locks();
        $display("test reset values done");
        // Walking one through set and clear of both banks
        for (int k = 0; k < 2; k++) begin
            for (int b = 0; b < 32; b++) begin
                apb(1'b1, 8'(16 * k + 4), 32'h1 << b);
                check_locks();
                apb(1'b0, 8'(16 * k), 32'h0);
                apb(1'b1, 8'(16 * k), 32'h1 << b);
                check_locks();
            end
        end
        $display("test bit mapping done");
        // Zeros leave everything alone, whichever register gets them
        apb(1'b1, 8'h04, 32'hffffffff);
        apb(1'b1, 8'h14, 32'hffffffff);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, addrTab[i], 32'h0);
            apb(1'b0, addrTab[i], 32'h0);
        end
        check_locks();
        $display("test zero writes done");
        // Random traffic, unmapped addresses among it
        for (int i = 0; i < 200; i++) begin
            apb(1'($urandom), addrTab[$urandom % 8],
                $urandom);
            check_locks();
        end
        $display("test random traffic done");
        // Reset in mid-run brings back the power-up values
        @(posedge mclk);
        do_reset();
        for (int i = 0; i < 4; i++)
            apb(1'b0, addrTab[i], 32'h0);
        check_locks();
        $display("test second reset done");
        report_and_stop();
    end
endmodule
